// ==== pkg/ssp_pkg.sv ====
// constants shared by the serial port pin block
package ssp_pkg;
	localparam int unsigned NUM_PINS = 6;
	localparam int unsigned ADDR_W = 8;
	// pin indices
	localparam int unsigned PIN_CTRL_A = 0;
	localparam int unsigned PIN_CTRL_B = 1;
	localparam int unsigned PIN_FRAME = 2;
	localparam int unsigned PIN_CLOCK = 3;
	localparam int unsigned PIN_RX = 4;
	localparam int unsigned PIN_TX = 5;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PORT_SEL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SER_CFG = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_TX_DATA = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
	// serial config fields
	localparam int unsigned CFG_ASYNC = 0;
	localparam int unsigned CFG_TX_EN = 1;
	localparam int unsigned CFG_RX_EN = 2;
	localparam int unsigned CFG_CLK_OUT = 3;
	localparam int unsigned CFG_FRAME_OUT = 4;
	localparam int unsigned CFG_A_OUT = 5;
	localparam int unsigned CFG_B_OUT = 6;
	localparam int unsigned CFG_A_TX = 7;
	localparam int unsigned CFG_B_TX = 8;
	localparam int unsigned CFG_FLAG0 = 9;
	localparam int unsigned CFG_FLAG1 = 10;
	localparam int unsigned CFG_FLAG_W = 11;
	localparam int unsigned CFG_DIV_LSB = 16;
	localparam int unsigned DIV_W = 8;
	// status fields
	localparam int unsigned ST_TX_FULL = 0;
	localparam int unsigned ST_RX_FULL = 1;
	localparam int unsigned ST_TX_BUSY = 2;
	localparam int unsigned ST_RX_BUSY = 3;
	localparam int unsigned ST_STOP = 4;
	localparam int unsigned ST_WAIT = 5;
	// reset values
	localparam logic [NUM_PINS-1:0] RST_PORT_SEL = 6'h00;
	localparam logic [NUM_PINS-1:0] RST_PORT_DIR = 6'h00;
	localparam logic [NUM_PINS-1:0] RST_PORT_DATA = 6'h00;
	localparam logic [CFG_FLAG_W-1:0] RST_SER_CFG = 11'h000;
	// half bit period in pclk cycles, at least three system phases
	localparam int unsigned DIV_MIN = 3;
	localparam logic [DIV_W-1:0] RST_DIV = 8'h04;
endpackage

// ==== pkg/ssp_sync_if.sv ====
// synchronised pin levels and link clock edges between sampler and port
`timescale 1ns/100ps
interface ssp_sync_if #(parameter int unsigned N = 6);
	logic [N-1:0] level;
	logic clk_rise;
	logic clk_fall;
	logic rxclk_rise;
	logic rxclk_fall;
	modport producer (output level, clk_rise, clk_fall, rxclk_rise, rxclk_fall);
	modport consumer (input level, clk_rise, clk_fall, rxclk_rise, rxclk_fall);
endinterface

// ==== rtl/ssp_pin_sampler.sv ====
// two-flop pin synchronisers with edge detection of the link clocks
`timescale 1ns/100ps
module ssp_pin_sampler #(
	parameter int unsigned N = 6
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw pins
	input wire logic [N-1:0] pin_raw,
	input wire logic hold,
	// synchronised view
	ssp_sync_if.producer sync
);
	logic [N-1:0] meta_reg;
	logic [N-1:0] sync_reg;
	logic [N-1:0] last_reg;

	// only the second stage reads the first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= pin_raw;
			sync_reg <= meta_reg;
		end
	end

	// frozen while stopped so inputs are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_reg <= '0;
		end else if (!hold) begin
			last_reg <= sync_reg;
		end
	end

	// edges need three pclk phases per half period to be seen
	always_comb begin
		sync.level = last_reg;
		sync.clk_rise = !hold && sync_reg[ssp_pkg::PIN_CLOCK] && !last_reg[ssp_pkg::PIN_CLOCK];
		sync.clk_fall = !hold && !sync_reg[ssp_pkg::PIN_CLOCK] && last_reg[ssp_pkg::PIN_CLOCK];
		sync.rxclk_rise = !hold && sync_reg[ssp_pkg::PIN_CTRL_A] && !last_reg[ssp_pkg::PIN_CTRL_A];
		sync.rxclk_fall = !hold && !sync_reg[ssp_pkg::PIN_CTRL_A] && last_reg[ssp_pkg::PIN_CTRL_A];
	end
endmodule

// ==== rtl/ssp_port.sv ====
// serial port pin block: pin sharing, gpio, and a small shift engine
// Overview of operation
// - async mode: control pin a is the receive bit clock, in or out.
// - sync mode: control pin a is transmitter 1 output or flag 0.
// - control pin b: async receive frame sync; sync transmitter 2 or flag 1.
// - frame pin: shared frame sync in sync mode, transmit only in async.
// - frame pin as output drives internal frame; as input takes external frame.
// - bit clock pin clocks both directions in sync, transmit only in async.
// - receive pin is an input, its bits shift into the receive register.
// - transmit pin is driven while transmitting, carrying shifted-out bits.
// - after reset all pins are gpio inputs; selection moves each to serial.
// - in gpio mode pin direction follows its direction register bit.
// - stop: inputs ignored, outputs tri-stated.
// - wait state leaves pin states and functions unchanged.
`timescale 1ns/100ps
module ssp_port #(
	parameter int unsigned WORD_BITS = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ssp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power states
	input wire logic stop_mode,
	input wire logic wait_mode,
	// port pins
	input wire logic [ssp_pkg::NUM_PINS-1:0] pin_in,
	output logic [ssp_pkg::NUM_PINS-1:0] pin_out,
	output logic [ssp_pkg::NUM_PINS-1:0] pin_oe
);
	localparam int unsigned NP = ssp_pkg::NUM_PINS;
	localparam int unsigned CW = $clog2(WORD_BITS + 1);

	// shifter slices need at least two bits, read data holds at most 32
	if (WORD_BITS < 2 || WORD_BITS > 32) begin : g_bad_width
		$error("WORD_BITS must be 2 to 32");
	end

	ssp_sync_if #(.N(NP)) sync ();

	ssp_pin_sampler #(.N(NP)) u_sampler (
		.pclk(pclk),
		.presetn(presetn),
		.pin_raw(pin_in),
		.hold(stop_mode),
		.sync(sync)
	);

	logic [NP-1:0] sel_reg;
	logic [NP-1:0] dir_reg;
	logic [NP-1:0] gpio_out_reg;
	logic [ssp_pkg::CFG_FLAG_W-1:0] cfg_reg;
	logic [ssp_pkg::DIV_W-1:0] div_reg;
	logic [WORD_BITS-1:0] tx_data_reg;
	logic [WORD_BITS-1:0] tx_shift_reg;
	logic [WORD_BITS-1:0] rx_shift_reg;
	logic [WORD_BITS-1:0] rx_data_reg;
	logic [CW-1:0] tx_cnt_reg;
	logic [CW-1:0] rx_cnt_reg;
	logic tx_full_reg;
	logic tx_busy_reg;
	logic rx_full_reg;
	logic rx_busy_reg;
	logic frame_int_reg;
	logic clk_int_reg;
	logic [ssp_pkg::DIV_W-1:0] div_cnt_reg;
	logic [31:0] prdata_reg;

	function automatic logic hit(input logic [ssp_pkg::ADDR_W-1:0] a, input logic [ssp_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign mapped = hit(paddr, ssp_pkg::OFS_PORT_SEL) || hit(paddr, ssp_pkg::OFS_PORT_DIR)
		|| hit(paddr, ssp_pkg::OFS_PORT_DATA) || hit(paddr, ssp_pkg::OFS_SER_CFG)
		|| hit(paddr, ssp_pkg::OFS_TX_DATA) || hit(paddr, ssp_pkg::OFS_RX_DATA)
		|| hit(paddr, ssp_pkg::OFS_STATUS);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = prdata_reg;

	logic async_mode;
	logic run;
	assign async_mode = cfg_reg[ssp_pkg::CFG_ASYNC];
	assign run = !stop_mode && (cfg_reg[ssp_pkg::CFG_TX_EN] || cfg_reg[ssp_pkg::CFG_RX_EN]);

	// per-pin selection and direction, all gpio inputs after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= ssp_pkg::RST_PORT_SEL;
			dir_reg <= ssp_pkg::RST_PORT_DIR;
			gpio_out_reg <= ssp_pkg::RST_PORT_DATA;
		end else if (wr) begin
			if (hit(paddr, ssp_pkg::OFS_PORT_SEL)) begin
				sel_reg <= pwdata[NP-1:0];
			end
			if (hit(paddr, ssp_pkg::OFS_PORT_DIR)) begin
				dir_reg <= pwdata[NP-1:0];
			end
			if (hit(paddr, ssp_pkg::OFS_PORT_DATA)) begin
				gpio_out_reg <= pwdata[NP-1:0];
			end
		end
	end

	// divider below the minimum is clamped so the pin clock stays legal
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= ssp_pkg::RST_SER_CFG;
			div_reg <= ssp_pkg::RST_DIV;
		end else if (wr && hit(paddr, ssp_pkg::OFS_SER_CFG)) begin
			cfg_reg <= pwdata[ssp_pkg::CFG_FLAG_W-1:0];
			if (pwdata[ssp_pkg::CFG_DIV_LSB +: ssp_pkg::DIV_W] < ssp_pkg::DIV_W'(ssp_pkg::DIV_MIN)) begin
				div_reg <= ssp_pkg::DIV_W'(ssp_pkg::DIV_MIN);
			end else begin
				div_reg <= pwdata[ssp_pkg::CFG_DIV_LSB +: ssp_pkg::DIV_W];
			end
		end
	end

	// internal bit clock from a pclk divider enable
	logic tick;
	assign tick = run && (div_cnt_reg == div_reg - 8'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= '0;
			clk_int_reg <= 1'b0;
		end else if (!run) begin
			div_cnt_reg <= '0;
		end else if (tick) begin
			div_cnt_reg <= '0;
			clk_int_reg <= !clk_int_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// clock and frame sources
	logic int_rise;
	logic int_fall;
	logic tx_rise;
	logic rx_fall;
	logic tx_frame;
	logic rx_frame;
	logic rx_bit;
	logic tx_start;
	assign int_rise = tick && !clk_int_reg;
	assign int_fall = tick && clk_int_reg;
	assign tx_rise = cfg_reg[ssp_pkg::CFG_CLK_OUT] ? int_rise : sync.clk_rise;
	always_comb begin
		if (async_mode) begin
			rx_fall = cfg_reg[ssp_pkg::CFG_A_OUT] ? int_fall : sync.rxclk_fall;
			rx_frame = cfg_reg[ssp_pkg::CFG_B_OUT] ? frame_int_reg : sync.level[ssp_pkg::PIN_CTRL_B];
		end else begin
			rx_fall = cfg_reg[ssp_pkg::CFG_CLK_OUT] ? int_fall : sync.clk_fall;
			rx_frame = cfg_reg[ssp_pkg::CFG_FRAME_OUT] ? frame_int_reg : sync.level[ssp_pkg::PIN_FRAME];
		end
	end
	assign tx_frame = cfg_reg[ssp_pkg::CFG_FRAME_OUT] || sync.level[ssp_pkg::PIN_FRAME];
	assign rx_bit = sync.level[ssp_pkg::PIN_RX];
	assign tx_start = tx_rise && cfg_reg[ssp_pkg::CFG_TX_EN] && tx_full_reg && !tx_busy_reg && tx_frame;

	// transmit holding register: a new write wins over the load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_full_reg <= 1'b0;
			tx_data_reg <= '0;
		end else if (wr && hit(paddr, ssp_pkg::OFS_TX_DATA)) begin
			tx_full_reg <= 1'b1;
			tx_data_reg <= pwdata[WORD_BITS-1:0];
		end else if (tx_start) begin
			tx_full_reg <= 1'b0;
		end
	end

	// transmit shifter, msb first, frame high for the first bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy_reg <= 1'b0;
			tx_shift_reg <= '0;
			tx_cnt_reg <= '0;
			frame_int_reg <= 1'b0;
		end else if (tx_rise) begin
			frame_int_reg <= tx_start;
			if (tx_start) begin
				tx_busy_reg <= 1'b1;
				tx_shift_reg <= tx_data_reg;
				tx_cnt_reg <= CW'(WORD_BITS - 1);
			end else if (tx_busy_reg) begin
				tx_shift_reg <= {tx_shift_reg[WORD_BITS-2:0], 1'b0};
				if (tx_cnt_reg == '0) begin
					tx_busy_reg <= 1'b0;
				end else begin
					tx_cnt_reg <= tx_cnt_reg - CW'(1);
				end
			end
		end
	end

	// receive shifter samples on the falling edge
	logic rx_done;
	assign rx_done = rx_fall && rx_busy_reg && (rx_cnt_reg == CW'(WORD_BITS - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy_reg <= 1'b0;
			rx_shift_reg <= '0;
			rx_cnt_reg <= '0;
			rx_data_reg <= '0;
		end else if (rx_fall && cfg_reg[ssp_pkg::CFG_RX_EN]) begin
			rx_shift_reg <= {rx_shift_reg[WORD_BITS-2:0], rx_bit};
			if (!rx_busy_reg && rx_frame) begin
				rx_busy_reg <= 1'b1;
				rx_cnt_reg <= CW'(1);
			end else if (rx_done) begin
				rx_busy_reg <= 1'b0;
				rx_data_reg <= {rx_shift_reg[WORD_BITS-2:0], rx_bit};
			end else if (rx_busy_reg) begin
				rx_cnt_reg <= rx_cnt_reg + CW'(1);
			end
		end
	end

	// word arrival beats a read in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_reg <= 1'b0;
		end else if (rx_done && cfg_reg[ssp_pkg::CFG_RX_EN]) begin
			rx_full_reg <= 1'b1;
		end else if (rd && hit(paddr, ssp_pkg::OFS_RX_DATA)) begin
			rx_full_reg <= 1'b0;
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (setup) begin
			prdata_reg <= '0;
			unique case (1'b1)
				hit(paddr, ssp_pkg::OFS_PORT_SEL): prdata_reg[NP-1:0] <= sel_reg;
				hit(paddr, ssp_pkg::OFS_PORT_DIR): prdata_reg[NP-1:0] <= dir_reg;
				hit(paddr, ssp_pkg::OFS_PORT_DATA): prdata_reg[NP-1:0] <= sync.level;
				hit(paddr, ssp_pkg::OFS_SER_CFG): begin
					prdata_reg[ssp_pkg::CFG_FLAG_W-1:0] <= cfg_reg;
					prdata_reg[ssp_pkg::CFG_DIV_LSB +: ssp_pkg::DIV_W] <= div_reg;
				end
				hit(paddr, ssp_pkg::OFS_TX_DATA): prdata_reg[WORD_BITS-1:0] <= tx_data_reg;
				hit(paddr, ssp_pkg::OFS_RX_DATA): prdata_reg[WORD_BITS-1:0] <= rx_data_reg;
				hit(paddr, ssp_pkg::OFS_STATUS): begin
					prdata_reg[ssp_pkg::ST_TX_FULL] <= tx_full_reg;
					prdata_reg[ssp_pkg::ST_RX_FULL] <= rx_full_reg;
					prdata_reg[ssp_pkg::ST_TX_BUSY] <= tx_busy_reg;
					prdata_reg[ssp_pkg::ST_RX_BUSY] <= rx_busy_reg;
					prdata_reg[ssp_pkg::ST_STOP] <= stop_mode;
					prdata_reg[ssp_pkg::ST_WAIT] <= wait_mode;
				end
				default: prdata_reg <= '0;
			endcase
		end
	end

	// pin mux; wait is only reported, it never gates a pin
	logic tx_bit;
	logic [NP-1:0] ser_out;
	logic [NP-1:0] ser_oe;
	assign tx_bit = tx_shift_reg[WORD_BITS-1];
	always_comb begin
		ser_out = '0;
		ser_oe = '0;
		if (async_mode) begin
			ser_out[ssp_pkg::PIN_CTRL_A] = clk_int_reg;
			ser_oe[ssp_pkg::PIN_CTRL_A] = cfg_reg[ssp_pkg::CFG_A_OUT];
			ser_out[ssp_pkg::PIN_CTRL_B] = frame_int_reg;
			ser_oe[ssp_pkg::PIN_CTRL_B] = cfg_reg[ssp_pkg::CFG_B_OUT];
		end else begin
			ser_out[ssp_pkg::PIN_CTRL_A] = cfg_reg[ssp_pkg::CFG_A_TX] ? tx_bit : cfg_reg[ssp_pkg::CFG_FLAG0];
			ser_oe[ssp_pkg::PIN_CTRL_A] = 1'b1;
			ser_out[ssp_pkg::PIN_CTRL_B] = cfg_reg[ssp_pkg::CFG_B_TX] ? tx_bit : cfg_reg[ssp_pkg::CFG_FLAG1];
			ser_oe[ssp_pkg::PIN_CTRL_B] = 1'b1;
		end
		ser_out[ssp_pkg::PIN_FRAME] = frame_int_reg;
		ser_oe[ssp_pkg::PIN_FRAME] = cfg_reg[ssp_pkg::CFG_FRAME_OUT];
		ser_out[ssp_pkg::PIN_CLOCK] = clk_int_reg;
		ser_oe[ssp_pkg::PIN_CLOCK] = cfg_reg[ssp_pkg::CFG_CLK_OUT];
		ser_out[ssp_pkg::PIN_TX] = tx_bit;
		ser_oe[ssp_pkg::PIN_TX] = tx_busy_reg;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_pin
			assign pin_out[gi] = sel_reg[gi] ? ser_out[gi] : gpio_out_reg[gi];
			assign pin_oe[gi] = !stop_mode && (sel_reg[gi] ? ser_oe[gi] : dir_reg[gi]);
		end
	endgenerate

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a write in the load cycle wins and keeps the holding register full
	sequence s_tx_load;
		tx_start && !(wr && hit(paddr, ssp_pkg::OFS_TX_DATA));
	endsequence
	sequence s_tx_shifting;
		tx_busy_reg && !tx_full_reg;
	endsequence
	property p_tx_load;
		s_tx_load |=> s_tx_shifting;
	endproperty

	a_tx_load_start: assert property (p_tx_load) else $error("tx load did not start shifting");
	a_gpio_dir_follow: assert property (!stop_mode |-> ((pin_oe & ~sel_reg) == (dir_reg & ~sel_reg)))
		else $error("gpio direction mismatch");
	a_stop_tristate: assert property (stop_mode |-> pin_oe == '0) else $error("pin driven in stop");
	a_rx_pin_input: assert property (sel_reg[ssp_pkg::PIN_RX] |-> !pin_oe[ssp_pkg::PIN_RX])
		else $error("rx pin driven");
	a_tx_drive_busy: assert property (sel_reg[ssp_pkg::PIN_TX] && !stop_mode |-> pin_oe[ssp_pkg::PIN_TX] == tx_busy_reg)
		else $error("tx pin enable wrong");
	a_frame_pin_out: assert property (sel_reg[ssp_pkg::PIN_FRAME] && cfg_reg[ssp_pkg::CFG_FRAME_OUT] && !stop_mode
		|-> pin_oe[ssp_pkg::PIN_FRAME] && pin_out[ssp_pkg::PIN_FRAME] == frame_int_reg)
		else $error("frame pin not driving");
	a_sync_flag_zero: assert property (sel_reg[ssp_pkg::PIN_CTRL_A] && !async_mode && !cfg_reg[ssp_pkg::CFG_A_TX]
		&& !stop_mode |-> pin_oe[ssp_pkg::PIN_CTRL_A] && pin_out[ssp_pkg::PIN_CTRL_A] == cfg_reg[ssp_pkg::CFG_FLAG0])
		else $error("flag 0 not on pin a");
	a_async_frame_in: assert property (sel_reg[ssp_pkg::PIN_CTRL_B] && async_mode && !cfg_reg[ssp_pkg::CFG_B_OUT]
		|-> !pin_oe[ssp_pkg::PIN_CTRL_B]) else $error("rx frame input driven");
	a_clock_half_min: assert property ($rose(clk_int_reg) |-> clk_int_reg[*3]) else $error("bit clock half too short");
	a_rx_word_full: assert property (rx_done && cfg_reg[ssp_pkg::CFG_RX_EN] |=> rx_full_reg && !rx_busy_reg)
		else $error("received word not flagged");
	a_select_write: assert property (wr && hit(paddr, ssp_pkg::OFS_PORT_SEL) |=> sel_reg == $past(pwdata[NP-1:0]))
		else $error("selection not stored");
	a_async_rx_clock: assert property (async_mode && !cfg_reg[ssp_pkg::CFG_A_OUT] && sel_reg[ssp_pkg::PIN_CTRL_A]
		&& !stop_mode |-> !pin_oe[ssp_pkg::PIN_CTRL_A]) else $error("rx clock input driven");
endmodule

// ==== verification/ssp_link_peer.sv ====
// behavioural far-side serial peer: bit clock, frame, receive data, transmit capture
`timescale 1ns/100ps
module ssp_link_peer (
	// control from bench
	input wire logic start,
	input wire logic [7:0] word,
	// lines seen
	input wire logic clk_lvl,
	input wire logic tx_lvl,
	input wire logic tx_oe,
	// lines driven and results
	output logic bclk,
	output logic frame,
	output logic rxd,
	output logic [7:0] cap,
	output logic done
);
	// 80 ns half period is four system clocks, above the three-phase floor
	localparam time HALF = 80;
	initial begin
		bclk = 1'b0;
		frame = 1'b0;
		rxd = 1'b0;
		cap = 8'h00;
		done = 1'b0;
	end
	// clock stands still low between frames; msb first, frame on the first bit
	always @(posedge start) begin
		done = 1'b0;
		#7;
		for (int i = 7; i >= 0; i--) begin
			rxd = word[i];
			frame = (i == 7);
			#(HALF / 2) bclk = 1'b1;
			#HALF bclk = 1'b0;
			#(HALF / 2) frame = 1'b0;
		end
		// released line must not echo the last bit
		rxd = ~word[0];
		done = 1'b1;
	end
	// device shifts on the rise, so take the bit at the fall
	always @(negedge clk_lvl) if (tx_oe) cap <= {cap[6:0], tx_lvl};
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the serial port pin block
`timescale 1ns/100ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic stop_mode, wait_mode, link_mode, start, bclk, frame, rxd, done;
	logic [7:0] paddr, cap;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] pin_out, pin_oe, gpio_drv, ext_lvl, pin_in;
	int bad_count, check_count;
	assign ext_lvl = link_mode ? {gpio_drv[5], rxd, bclk, frame, gpio_drv[1:0]} : gpio_drv;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	ssp_port #(.WORD_BITS(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_mode(stop_mode), .wait_mode(wait_mode), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	ssp_link_peer peer (.start(start), .word(8'h3c), .clk_lvl(pin_in[3]), .tx_lvl(pin_in[5]),
		.tx_oe(pin_oe[5]), .bclk(bclk), .frame(frame), .rxd(rxd), .cap(cap), .done(done));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// one apb transfer; no wait count assumed, the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	// let the synchronisers and registers land before looking at pins
	task automatic settle;
		repeat (4) @(posedge pclk);
		#1;
	endtask
	task automatic wait_tx(input logic lvl);
		while (pin_oe[5] !== lvl) begin
			@(posedge pclk);
		end
		#1;
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, stop_mode, wait_mode, link_mode, start} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		gpio_drv = 6'h00;
		bad_count = 0;
		check_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		#1 chk("reset oe", 32'h0, pin_oe);
		rchk("sel reset", ssp_pkg::OFS_PORT_SEL, 32'h0);
		chk("mapped read err", 32'h0, {31'h0, err});
		chk("ready", 32'h1, {31'h0, pready});
		rchk("dir reset", ssp_pkg::OFS_PORT_DIR, 32'h0);
		rchk("cfg reset", ssp_pkg::OFS_SER_CFG, 32'h0004_0000);
		wr(ssp_pkg::OFS_PORT_DATA, 32'h2a);
		wr(ssp_pkg::OFS_PORT_DIR, 32'h05);
		settle;
		chk("oe per pin", 32'h05, pin_oe);
		wr(ssp_pkg::OFS_PORT_DIR, 32'h3f);
		settle;
		chk("gpio oe", 32'h3f, pin_oe);
		chk("gpio out", 32'h2a, pin_out);
		// unmapped place: error, zero data, no side effect
		apb(1'b1, 8'h1c, 32'h0);
		chk("unmapped write err", 32'h1, err);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped read", 32'h0, rd);
		rchk("dir kept", ssp_pkg::OFS_PORT_DIR, 32'h3f);
		@(posedge pclk) wait_mode <= 1'b1;
		settle;
		chk("wait oe", 32'h3f, pin_oe);
		chk("wait out", 32'h2a, pin_out);
		rchk("wait status", ssp_pkg::OFS_STATUS, 32'h20);
		@(posedge pclk) wait_mode <= 1'b0;
		@(posedge pclk) stop_mode <= 1'b1;
		settle;
		chk("stop oe", 32'h0, pin_oe);
		@(posedge pclk) stop_mode <= 1'b0;
		settle;
		chk("after stop oe", 32'h3f, pin_oe);
		wr(ssp_pkg::OFS_PORT_DIR, 32'h0);
		@(posedge pclk) gpio_drv <= 6'h2a;
		settle;
		rchk("gpio in", ssp_pkg::OFS_PORT_DATA, 32'h2a);
		@(posedge pclk) stop_mode <= 1'b1;
		@(posedge pclk) gpio_drv <= 6'h15;
		settle;
		rchk("stop in ignored", ssp_pkg::OFS_PORT_DATA, 32'h2a);
		@(posedge pclk) stop_mode <= 1'b0;
		wr(ssp_pkg::OFS_PORT_SEL, 32'h3f);
		// sync flags on control pins a and b, every combination
		for (int f = 0; f < 4; f++) begin
			wr(ssp_pkg::OFS_SER_CFG, 32'h0004_0000 | (32'(f) << 9));
			settle;
			chk("flag oe", 32'h3, {30'h0, pin_oe[1:0]});
			chk("flag out", 32'(f), {30'h0, pin_out[1:0]});
		end
		// async: frame out, pin a out, pin b out, one at a time
		for (int i = 0; i < 3; i++) begin
			wr(ssp_pkg::OFS_SER_CFG, 32'h0004_0001 | (32'h10 << i));
			settle;
			chk("async oe", 32'(1 << ((i + 2) % 3)), pin_oe);
		end
		wr(ssp_pkg::OFS_SER_CFG, 32'h0004_001a);
		wr(ssp_pkg::OFS_TX_DATA, 32'ha5);
		wait_tx(1'b1);
		chk("tx clock frame oe", 32'h3, {30'h0, pin_oe[3:2]});
		wait_tx(1'b0);
		settle;
		chk("tx word", 32'ha5, {24'h0, cap});
		wr(ssp_pkg::OFS_SER_CFG, 32'h0004_0004);
		settle;
		chk("rx oe", 32'h03, pin_oe);
		@(posedge pclk) link_mode <= 1'b1;
		@(posedge pclk) start <= 1'b1;
		while (done !== 1'b1) @(posedge pclk);
		start <= 1'b0;
		settle;
		rchk("rx status", ssp_pkg::OFS_STATUS, 32'h02);
		rchk("rx word", ssp_pkg::OFS_RX_DATA, 32'h3c);
		give_verdict;
	end
	initial begin
		#1000000;
		bad_count++;
		give_verdict;
	end
endmodule
